// ---- logic/tcs_alarm_pkg.sv ----
`default_nettype none
package supervision_pkg;
	localparam int unsigned CLK_HZ       = 50_000_000;
	// Times in ms
	localparam int unsigned DROP_OFF_MS  = 400;
	localparam int unsigned PICK_UP_MS   = 50;
	// Cycle counts derived from the clock rate
	localparam int unsigned DROP_OFF_CYC = DROP_OFF_MS * (CLK_HZ / 1000);
	localparam int unsigned PICK_UP_CYC  = PICK_UP_MS * (CLK_HZ / 1000);
	localparam int unsigned CNT_W        = 25;

	typedef enum logic [1:0] {
		SRC_CLOSED_ONLY,
		SRC_OPEN_ONLY,
		SRC_BOTH
	} status_source_t;

	// Opto-inputs from the trip circuit
	typedef struct packed {
		logic closed_path;
		logic open_path;
	} opto_in_t;

	typedef struct packed {
		logic relay_nc_closed;
		logic indicator;
		logic user_alarm;
		logic breaker_closed;
		logic breaker_state_valid;
	} alarm_out_t;
endpackage : supervision_pkg
`default_nettype wire

// ---- logic/trip_circuit_supervision_alarm.sv ----
`default_nettype none
module trip_circuit_supervision_alarm
	import supervision_pkg::*;
#(
	parameter int unsigned DROP_OFF_CYCLES = DROP_OFF_CYC,
	parameter int unsigned PICK_UP_CYCLES  = PICK_UP_CYC
) (
	input  wire logic                            ref_clk,         // 50 MHz clock
	input  wire logic                            srst,            // Sync reset, high
	input  wire logic                            two_input_mode,  // 1: two-input scheme
	input  wire supervision_pkg::status_source_t src_sel,         // Breaker state source
	input  wire supervision_pkg::opto_in_t       opto,            // Opto-inputs
	input  wire logic                            indicator_reset, // Indicator clear request
	output var  supervision_pkg::alarm_out_t     alarm_o          // Registered outputs
);
	import supervision_pkg::*;

	// Counters are CNT_W wide; longer delays need a wider counter
	if (DROP_OFF_CYCLES < 1 || DROP_OFF_CYCLES >= (1 << CNT_W)) begin : g_drop_off_range
		$error("DROP_OFF_CYCLES out of range");
	end
	if (PICK_UP_CYCLES < 1 || PICK_UP_CYCLES >= (1 << CNT_W)) begin : g_pick_up_range
		$error("PICK_UP_CYCLES out of range");
	end

	// Shared end test of both delay counters
	function automatic logic at_end(
		input logic [CNT_W-1:0] cnt,
		input int unsigned      cycles
	);
		return cnt == CNT_W'(cycles - 1);
	endfunction : at_end

	typedef struct packed {
		logic [CNT_W-1:0] hold_cnt;
		logic             superv;
		logic [CNT_W-1:0] pu_cnt;
		logic             fail;
		logic             was_closed;
		alarm_out_t       out;
	} state_t;

	state_t st_q, st_d;
	logic   energised;
	logic   brk_closed;
	logic   brk_valid;

	always_comb begin
		energised = two_input_mode ? (opto.closed_path | opto.open_path) : opto.closed_path;
		case (src_sel)
			SRC_CLOSED_ONLY: begin
				brk_closed = opto.closed_path;
				brk_valid  = 1'b1;
			end
			SRC_OPEN_ONLY: begin
				brk_closed = ~opto.open_path;
				brk_valid  = 1'b1;
			end
			SRC_BOTH: begin
				brk_closed = opto.closed_path;
				brk_valid  = opto.closed_path ^ opto.open_path;
			end
			default: begin
				brk_closed = 1'b0;
				brk_valid  = 1'b0;
			end
		endcase
	end

	always_comb begin
		st_d = st_q;
		// drop-off delay timer
		// Any energised cycle restarts the count, so dips never add up
		if (energised) begin
			st_d.superv   = 1'b1;
			st_d.hold_cnt = '0;
		end else if (st_q.superv) begin
			if (at_end(st_q.hold_cnt, DROP_OFF_CYCLES))
				st_d.superv = 1'b0;
			else
				st_d.hold_cnt = st_q.hold_cnt + 1'b1;
		end
		if (st_q.superv) begin
			st_d.pu_cnt = '0;
			st_d.fail   = 1'b0;
		end else if (!st_q.fail) begin
			if (at_end(st_q.pu_cnt, PICK_UP_CYCLES))
				st_d.fail = 1'b1;
			else
				st_d.pu_cnt = st_q.pu_cnt + 1'b1;
		end
		if (brk_valid && brk_closed)
			st_d.was_closed = 1'b1;
		st_d.out.relay_nc_closed = ~st_q.superv;
		st_d.out.user_alarm = st_q.fail && (!two_input_mode || st_q.was_closed);
		if (st_d.out.user_alarm)
			st_d.out.indicator = 1'b1;
		else if (indicator_reset && !st_q.fail)
			st_d.out.indicator = 1'b0;
		if (st_q.superv) begin
			st_d.out.user_alarm = 1'b0;
			if (indicator_reset)
				st_d.out.indicator = 1'b0;
		end
		st_d.out.breaker_closed      = brk_closed;
		st_d.out.breaker_state_valid = brk_valid;
	end

	always_ff @(posedge ref_clk) begin
		if (srst)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign alarm_o = st_q.out;

	// Assertions
	a_superv_rise: assert property (@(posedge ref_clk) disable iff (srst)
		energised |=> st_q.superv) else $error("supervision not set");
	a_superv_hold: assert property (@(posedge ref_clk) disable iff (srst)
		$fell(energised) |=> st_q.superv [*8]) else $error("supervision dropped early");
	a_relay_open: assert property (@(posedge ref_clk) disable iff (srst)
		st_q.superv |=> !alarm_o.relay_nc_closed) else $error("relay not open");
	a_alarm_reset: assert property (@(posedge ref_clk) disable iff (srst)
		st_q.superv |=> !alarm_o.user_alarm) else $error("user alarm not reset");
	a_pickup_delay: assert property (@(posedge ref_clk) disable iff (srst)
		$fell(st_q.superv) |=> !st_q.fail [*2]) else $error("pick-up too fast");
	a_indicator_set: assert property (@(posedge ref_clk) disable iff (srst)
		alarm_o.user_alarm |-> alarm_o.indicator) else $error("indicator not set");
	a_two_input: assert property (@(posedge ref_clk) disable iff (srst)
		two_input_mode && (opto.closed_path || opto.open_path) |=> st_q.superv)
		else $error("single low input raised failure");
	a_closed_first: assert property (@(posedge ref_clk) disable iff (srst)
		two_input_mode && !st_q.was_closed |=> !alarm_o.user_alarm)
		else $error("fault reported before closing");
	a_latch_hold: assert property (@(posedge ref_clk) disable iff (srst)
		alarm_o.indicator && !indicator_reset |=> alarm_o.indicator)
		else $error("indicator cleared without reset");

	// Drop-off timing
	a_drop_early: assert property (@(posedge ref_clk) disable iff (srst)
		st_q.superv && !energised && !at_end(st_q.hold_cnt, DROP_OFF_CYCLES) |=> st_q.superv)
		else $error("supervision dropped before its count ended");
	a_drop_end: assert property (@(posedge ref_clk) disable iff (srst)
		st_q.superv && !energised && at_end(st_q.hold_cnt, DROP_OFF_CYCLES) |=> !st_q.superv)
		else $error("supervision held past its count");

	// Relay and alarm reset
	a_relay_closed: assert property (@(posedge ref_clk) disable iff (srst)
		!st_q.superv |=> alarm_o.relay_nc_closed)
		else $error("relay not closed after supervision loss");
	a_fail_cleared: assert property (@(posedge ref_clk) disable iff (srst)
		st_q.superv |=> !st_q.fail)
		else $error("failure kept while supervised");

	// Pick-up timing
	a_pickup_early: assert property (@(posedge ref_clk) disable iff (srst)
		!st_q.superv && !st_q.fail && !at_end(st_q.pu_cnt, PICK_UP_CYCLES) |=> !st_q.fail)
		else $error("failure set before pick-up ended");
	a_pickup_end: assert property (@(posedge ref_clk) disable iff (srst)
		!st_q.superv && !st_q.fail && at_end(st_q.pu_cnt, PICK_UP_CYCLES) |=> st_q.fail)
		else $error("failure not set at pick-up end");
	a_fail_gate: assert property (@(posedge ref_clk) disable iff (srst)
		!st_q.fail |=> !alarm_o.user_alarm)
		else $error("user alarm without delayed failure");

	// Alarm outputs
	a_user_follow: assert property (@(posedge ref_clk) disable iff (srst)
		st_q.fail && !st_q.superv && (!two_input_mode || st_q.was_closed) |=> alarm_o.user_alarm)
		else $error("user alarm missing");

	// Two-input scheme and breaker state source
	a_single_low: assert property (@(posedge ref_clk) disable iff (srst)
		two_input_mode && (opto.closed_path ^ opto.open_path) |=> st_q.superv)
		else $error("one low input dropped supervision");
	a_state_both: assert property (@(posedge ref_clk) disable iff (srst)
		src_sel == SRC_BOTH && opto.closed_path == opto.open_path
		|=> !alarm_o.breaker_state_valid) else $error("breaker state valid on equal inputs");
	a_state_open: assert property (@(posedge ref_clk) disable iff (srst)
		src_sel == SRC_OPEN_ONLY |=> alarm_o.breaker_state_valid
		&& alarm_o.breaker_closed == !$past(opto.open_path)) else $error("open contact state wrong");
	a_state_closed: assert property (@(posedge ref_clk) disable iff (srst)
		src_sel == SRC_CLOSED_ONLY |=> alarm_o.breaker_state_valid
		&& alarm_o.breaker_closed == $past(opto.closed_path)) else $error("closed contact state wrong");
	a_closed_memory: assert property (@(posedge ref_clk) disable iff (srst)
		brk_valid && brk_closed |=> st_q.was_closed)
		else $error("breaker closing not remembered");
	a_closed_sticky: assert property (@(posedge ref_clk) disable iff (srst)
		st_q.was_closed |=> st_q.was_closed)
		else $error("breaker closing memory lost");

	// Indicator clear
	a_indicator_clear: assert property (@(posedge ref_clk) disable iff (srst)
		indicator_reset && !st_q.fail |=> !alarm_o.indicator)
		else $error("indicator not cleared by reset");

	c_alarm:  cover property (@(posedge ref_clk) $rose(alarm_o.user_alarm));
	c_clear:  cover property (@(posedge ref_clk) $fell(alarm_o.indicator));
	c_dip:    cover property (@(posedge ref_clk) $fell(energised) ##1 energised);
	c_closed: cover property (@(posedge ref_clk) alarm_o.breaker_closed && src_sel == SRC_BOTH);
	c_open:   cover property (@(posedge ref_clk) alarm_o.breaker_state_valid && src_sel == SRC_OPEN_ONLY);
endmodule : trip_circuit_supervision_alarm
`default_nettype wire

// ---- verification/breaker_optos.sv ----
`default_nettype none
module breaker_optos
	import supervision_pkg::*;
(
	input  wire logic               ref_clk,    // Clock
	input  wire logic               brk_closed, // Breaker position
	input  wire logic               path_ok,    // Trip path intact
	output var  supervision_pkg::opto_in_t opto // Opto-inputs
);
	timeunit 1ns;
	timeprecision 1ns;
	always_ff @(posedge ref_clk) begin
		opto.closed_path <= path_ok & brk_closed;
		opto.open_path   <= path_ok & ~brk_closed;
	end
endmodule : breaker_optos
`default_nettype wire

// ---- verification/trip_circuit_supervision_alarm_tb_top.sv ----
`default_nettype none
module trip_circuit_supervision_alarm_tb_top;
	import supervision_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int DO = 20;
	localparam int PU = 8;
	logic           ref_clk, srst, two_input_mode, indicator_reset, brk_closed, path_ok, smp;
	status_source_t src_sel;
	opto_in_t       opto;
	alarm_out_t     alarm_o, am, ae;
	alarm_out_t     eq[$], mq[$];
	int             fails, n_tests, cyc;
	logic [15:0]    rnd;
	breaker_optos u_far (.ref_clk(ref_clk), .brk_closed(brk_closed), .path_ok(path_ok), .opto(opto));
	trip_circuit_supervision_alarm #(.DROP_OFF_CYCLES(DO), .PICK_UP_CYCLES(PU)) u_dut (
		.ref_clk(ref_clk), .srst(srst), .two_input_mode(two_input_mode), .src_sel(src_sel),
		.opto(opto), .indicator_reset(indicator_reset), .alarm_o(alarm_o));
	function automatic logic [15:0] xs(input logic [15:0] v);
		v ^= v << 7;
		v ^= v >> 9;
		v ^= v << 8;
		return v;
	endfunction : xs
	task automatic step(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : step
	task automatic note(input alarm_out_t m, input alarm_out_t e);
		mq.push_back(m);
		eq.push_back(e);
		smp <= 1'b1;
		@(posedge ref_clk);
		smp <= 1'b0;
	endtask : note
	task automatic check(input alarm_out_t s, input alarm_out_t e);
		n_tests++;
		if (s !== e) begin
			fails++;
			$display("[FAIL] alarm_o expected %h seen %h", e, s);
		end
	endtask : check
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : stop_test
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	// Mid-cycle look, so the outputs have settled after their edge
	always @(negedge ref_clk) begin
		if (smp === 1'b1) begin
			am = mq.pop_front();
			ae = eq.pop_front();
			check(alarm_o & am, ae);
		end
	end
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			fails++;
			stop_test();
		end
	end
	initial begin
		{srst, two_input_mode, indicator_reset, smp} = 4'h8;
		{brk_closed, path_ok} = 2'h3;
		src_sel = SRC_CLOSED_ONLY;
		{fails, n_tests, cyc} = '0;
		rnd = xs(16'h9D27);
		step(3);
		srst <= 1'b0;
		step(6);
		note(5'h1C, 5'h00);
		path_ok <= 1'b0;
		step(1 + rnd[3:0] % 12);
		path_ok <= 1'b1;
		step(4);
		note(5'h1C, 5'h00);
		path_ok <= 1'b0;
		step(DO - 4);
		note(5'h10, 5'h00);
		step(8);
		note(5'h14, 5'h10);
		step(10);
		note(5'h1C, 5'h1C);
		indicator_reset <= 1'b1;
		step(2);
		indicator_reset <= 1'b0;
		note(5'h08, 5'h08);
		path_ok <= 1'b1;
		step(6);
		note(5'h1C, 5'h08);
		indicator_reset <= 1'b1;
		step(1);
		indicator_reset <= 1'b0;
		step(2);
		note(5'h08, 5'h00);
		$display("single input test done");
		srst <= 1'b1;
		two_input_mode <= 1'b1;
		src_sel <= SRC_BOTH;
		brk_closed <= 1'b0;
		path_ok <= 1'b0;
		step(2);
		srst <= 1'b0;
		step(DO + PU + 6);
		note(5'h0C, 5'h00);
		path_ok <= 1'b1;
		step(3);
		note(5'h03, 5'h01);
		brk_closed <= 1'b1;
		step(DO + PU + 6);
		note(5'h1F, 5'h03);
		path_ok <= 1'b0;
		step(DO + PU + 8);
		note(5'h1C, 5'h1C);
		src_sel <= SRC_OPEN_ONLY;
		step(2);
		note(5'h03, 5'h03);
		$display("two input test done");
		stop_test();
	end
endmodule : trip_circuit_supervision_alarm_tb_top
`default_nettype wire
